// >>> hbf_pkg.sv
// Package for host buffer feature configuration block
package hbf_pkg;
    // Feature identifiers
    localparam logic [7:0]  HBF_FID_HOSTBUF    = 8'h0d;
    localparam logic [7:0]  HBF_FID_KEEPALIVE  = 8'h0f;
    localparam logic [7:0]  HBF_FID_PROGRESS   = 8'h80;
    // Command dword 11 field positions
    localparam int          HBF_ENABLE_BIT_POS = 0;
    localparam int          HBF_RETURN_BIT_POS = 1;
    localparam int          HBF_COUNTER_MSB    = 7;
    // Descriptor entry layout (bits of 128-bit entry)
    localparam int          HBF_ENTRY_BYTES    = 16;
    localparam int          HBF_ENTRY_ADDR_LSB = 0;
    localparam int          HBF_ENTRY_PAGE_LSB = 64;
    localparam int          HBF_ALIGN_BITS     = 4;
    // Attributes structure dword index
    localparam logic [9:0]  HBF_ATTR_SIZE_IDX  = 10'h000;
    localparam logic [9:0]  HBF_ATTR_LOW_IDX   = 10'h001;
    localparam logic [9:0]  HBF_ATTR_HIGH_IDX  = 10'h002;
    localparam logic [9:0]  HBF_ATTR_COUNT_IDX = 10'h003;
    localparam logic [9:0]  HBF_ATTR_LAST_IDX  = 10'h3ff;
    // Reset values
    localparam logic [31:0] HBF_KEEPALIVE_RST  = 32'h0000_0000;
    localparam logic [7:0]  HBF_COUNTER_RST    = 8'h00;
    // Keep-alive timer granularity in milliseconds
    localparam logic [31:0] HBF_KEEPALIVE_GRAN = 32'h0000_0064;
    // Fetch state machine
    typedef enum logic [3:0] {
        HBF_IDLE  = 4'b0001,
        HBF_REQ   = 4'b0010,
        HBF_WAIT  = 4'b0100,
        HBF_SEND  = 4'b1000
    } hbf_state_t;
endpackage

// >>> hbf_roundup.sv
// Rounds a millisecond timeout up to the timer granularity, saturating at the largest 32-bit multiple
`timescale 1ns/100ps
module hbf_roundup (
    // Requested value
    input  wire logic [31:0] value_ms,
    // Rounded value, saturating at the largest multiple
    output logic      [31:0] rounded_ms
);
    import hbf_pkg::*;
    logic [32:0] sum;
    logic [32:0] q;
    always_comb begin
        sum = {1'b0, value_ms} + {1'b0, HBF_KEEPALIVE_GRAN} - 33'h1;
        q   = sum - (sum % {1'b0, HBF_KEEPALIVE_GRAN});
        // Top values would overflow 32 bits; clamp to last representable step
        if (q[32]) begin
            rounded_ms = value_ms - (value_ms % HBF_KEEPALIVE_GRAN);
        end else begin
            rounded_ms = q[31:0];
        end
    end
endmodule

// >>> hbf_feature_ctrl.sv
// Host buffer, keep-alive and progress marker feature handling
// How it works
// - Dword 14 set command stores the descriptor list upper address, all 32 bits.
// - Dword 15 set command stores the descriptor entry count, all 32 bits.
// - Entry n is fetched from list base plus sixteen times n.
// - Entry bits 95:64 are page count, 63:0 host address, 127:96 ignored.
// - Buffer read returns enable and return bits, plus attributes in data.
// - Attributes: size, address low, address high, count; rest zero.
// - Descriptor list base keeps its four low address bits zero.
// - Keep-alive timeout is a 32-bit millisecond value from dword 11.
// - Programmed keep-alive timeout rounds up to timer granularity, saturating at the largest 32-bit multiple.
// - Keep-alive resets to zero; zero disables the timer.
// - Keep-alive read returns current timeout in completion dword 0.
// - Load counter survives power state changes; only reset or a progress marker set command changes it.
// - Load counter is 8 bits in 7:0, upper bits read zero.
// - Progress marker read returns the counter in completion dword 0.
// - No buffer memory access while the enable bit is zero.
`timescale 1ns/100ps
module hbf_feature_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Feature command, pulse
    input  wire logic        cmd_valid,
    input  wire logic        cmd_is_set,
    input  wire logic [7:0]  cmd_feature_id,
    input  wire logic [31:0] cmd_dw11,
    input  wire logic [31:0] cmd_dw12,
    input  wire logic [31:0] cmd_dw13,
    input  wire logic [31:0] cmd_dw14,
    input  wire logic [31:0] cmd_dw15,
    // Completion
    output logic             cpl_valid,
    output logic      [31:0] cpl_dw0,
    // Attributes data stream, one dword per beat
    output logic             attr_valid,
    output logic      [9:0]  attr_index,
    output logic      [31:0] attr_data,
    // Descriptor fetch from host memory
    output logic             fetch_req,
    output logic      [63:0] fetch_addr,
    input  wire logic        fetch_ack,
    input  wire logic [127:0] fetch_entry,
    // Fetched descriptor
    output logic             entry_valid,
    output logic      [31:0] entry_index,
    output logic      [31:0] entry_page_count,
    output logic      [63:0] entry_host_address,
    // Status
    output logic             buffer_enable_bit,
    output logic             buffer_return_bit,
    output logic      [31:0] keepalive_timeout_ms,
    output logic             keepalive_enabled,
    output logic      [7:0]  preboot_load_counter,
    output logic             fetch_busy
);
    import hbf_pkg::*;

    // Feature state
    logic        enable_reg, enable_next;
    logic        ret_reg, ret_next;
    logic [31:0] size_reg, size_next;
    logic [31:0] low_reg, low_next;
    logic [31:0] high_reg, high_next;
    logic [31:0] count_reg, count_next;
    logic [31:0] keepalive_timeout_ms_reg, keepalive_timeout_ms_next;
    logic [7:0]  pbc_reg, pbc_next;
    logic [31:0] keepalive_timeout_ms_rounded;

    // Completion and attribute stream
    logic        cpl_valid_reg, cpl_valid_next;
    logic [31:0] cpl_dw0_reg, cpl_dw0_next;
    logic        attr_active_reg, attr_active_next;
    logic [9:0]  attr_idx_reg, attr_idx_next;
    logic [31:0] attr_data_next;
    logic [31:0] attr_data_reg;

    // Fetch engine
    hbf_state_t  state_reg, state_next;
    logic [31:0] fidx_reg, fidx_next;
    logic [31:0] epc_reg, epc_next;
    logic [63:0] eha_reg, eha_next;
    logic        ev_reg, ev_next;
    logic [63:0] list_base;
    logic [63:0] entry_offset;

    logic set_hb;
    logic set_ka;
    logic set_pb;

    hbf_roundup u_roundup (
        .value_ms   (cmd_dw11),
        .rounded_ms (keepalive_timeout_ms_rounded)
    );

    always_comb begin
        set_hb = cmd_valid && cmd_is_set && cmd_feature_id == HBF_FID_HOSTBUF;
        set_ka = cmd_valid && cmd_is_set && cmd_feature_id == HBF_FID_KEEPALIVE;
        set_pb = cmd_valid && cmd_is_set && cmd_feature_id == HBF_FID_PROGRESS;
    end

    // Feature settings
    always_comb begin
        enable_next = enable_reg;
        ret_next    = ret_reg;
        size_next   = size_reg;
        low_next    = low_reg;
        high_next   = high_reg;
        count_next  = count_reg;
        keepalive_timeout_ms_next   = keepalive_timeout_ms_reg;
        pbc_next    = pbc_reg;
        // Buffer settings only change through a set command; a change while
        // enabled restarts the fetch only from idle; a running fetch carries on at its index
        if (set_hb) begin
            enable_next = cmd_dw11[HBF_ENABLE_BIT_POS];
            ret_next    = cmd_dw11[HBF_RETURN_BIT_POS];
            size_next   = cmd_dw12;
            low_next    = {cmd_dw13[31:HBF_ALIGN_BITS], {HBF_ALIGN_BITS{1'b0}}};
            high_next   = cmd_dw14;
            count_next  = cmd_dw15;
        end
        if (set_ka) begin
            keepalive_timeout_ms_next = keepalive_timeout_ms_rounded;
        end
        // Counter value is whatever software writes; saturation is software's job
        if (set_pb) begin
            pbc_next = cmd_dw11[HBF_COUNTER_MSB:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg <= 1'b0;
            ret_reg    <= 1'b0;
            size_reg   <= 32'h0000_0000;
            low_reg    <= 32'h0000_0000;
            high_reg   <= 32'h0000_0000;
            count_reg  <= 32'h0000_0000;
            keepalive_timeout_ms_reg   <= HBF_KEEPALIVE_RST;
            pbc_reg    <= HBF_COUNTER_RST;
        end else begin
            enable_reg <= enable_next;
            ret_reg    <= ret_next;
            size_reg   <= size_next;
            low_reg    <= low_next;
            high_reg   <= high_next;
            count_reg  <= count_next;
            keepalive_timeout_ms_reg   <= keepalive_timeout_ms_next;
            pbc_reg    <= pbc_next;
        end
    end

    // Get responses and attribute structure
    always_comb begin
        cpl_valid_next   = 1'b0;
        cpl_dw0_next     = cpl_dw0_reg;
        attr_active_next = attr_active_reg;
        attr_idx_next    = attr_idx_reg;
        if (cmd_valid) begin
            cpl_valid_next = 1'b1;
            cpl_dw0_next   = 32'h0000_0000;
            if (!cmd_is_set) begin
                unique case (cmd_feature_id)
                    HBF_FID_HOSTBUF: begin
                        cpl_dw0_next[HBF_ENABLE_BIT_POS] = enable_reg;
                        cpl_dw0_next[HBF_RETURN_BIT_POS] = ret_reg;
                        attr_active_next = 1'b1;
                        attr_idx_next    = 10'h000;
                    end
                    HBF_FID_KEEPALIVE: cpl_dw0_next = keepalive_timeout_ms_reg;
                    HBF_FID_PROGRESS:  cpl_dw0_next = {24'h000000, pbc_reg};
                    default:           cpl_dw0_next = 32'h0000_0000;
                endcase
            end
        end else if (attr_active_reg) begin
            if (attr_idx_reg == HBF_ATTR_LAST_IDX) begin
                attr_active_next = 1'b0;
            end else begin
                attr_idx_next = attr_idx_reg + 10'h001;
            end
        end
        // Attributes dwords; reserved tail reads zero
        unique case (attr_idx_next)
            HBF_ATTR_SIZE_IDX:  attr_data_next = size_reg;
            HBF_ATTR_LOW_IDX:   attr_data_next = low_reg;
            HBF_ATTR_HIGH_IDX:  attr_data_next = high_reg;
            HBF_ATTR_COUNT_IDX: attr_data_next = count_reg;
            default:            attr_data_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpl_valid_reg   <= 1'b0;
            cpl_dw0_reg     <= 32'h0000_0000;
            attr_active_reg <= 1'b0;
            attr_idx_reg    <= 10'h000;
            attr_data_reg   <= 32'h0000_0000;
        end else begin
            cpl_valid_reg   <= cpl_valid_next;
            cpl_dw0_reg     <= cpl_dw0_next;
            attr_active_reg <= attr_active_next;
            attr_idx_reg    <= attr_idx_next;
            attr_data_reg   <= attr_data_next;
        end
    end

    // Descriptor fetch engine
    always_comb begin
        state_next = state_reg;
        fidx_next  = fidx_reg;
        epc_next   = epc_reg;
        eha_next   = eha_reg;
        ev_next    = 1'b0;
        unique case (state_reg)
            HBF_IDLE: begin
                // Start on a fresh enable; nothing to do for an empty list
                if (set_hb && cmd_dw11[HBF_ENABLE_BIT_POS] && cmd_dw15 != 32'h0000_0000) begin
                    fidx_next  = 32'h0000_0000;
                    state_next = HBF_REQ;
                end
            end
            HBF_REQ: begin
                if (!enable_reg) begin
                    state_next = HBF_IDLE;
                end else begin
                    state_next = HBF_WAIT;
                end
            end
            HBF_WAIT: begin
                // A dropped request is never answered, so waiting on would hang
                if (fetch_ack) begin
                    eha_next   = fetch_entry[HBF_ENTRY_ADDR_LSB +: 64];
                    epc_next   = fetch_entry[HBF_ENTRY_PAGE_LSB +: 32];
                    ev_next    = enable_reg;
                    state_next = HBF_SEND;
                end else if (!enable_reg) begin
                    state_next = HBF_IDLE;
                end
            end
            HBF_SEND: begin
                // Stop on disable or after the last counted entry
                if (!enable_reg || fidx_reg + 32'h1 >= count_reg) begin
                    state_next = HBF_IDLE;
                end else begin
                    fidx_next  = fidx_reg + 32'h1;
                    state_next = HBF_REQ;
                end
            end
            default: state_next = HBF_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= HBF_IDLE;
            fidx_reg  <= 32'h0000_0000;
            epc_reg   <= 32'h0000_0000;
            eha_reg   <= 64'h0;
            ev_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            fidx_reg  <= fidx_next;
            epc_reg   <= epc_next;
            eha_reg   <= eha_next;
            ev_reg    <= ev_next;
        end
    end

    // List addressing; full index kept so large counts do not alias
    assign list_base    = {high_reg, low_reg};
    assign entry_offset = {28'h0000000, fidx_reg, 4'h0};

    // Outputs
    assign cpl_valid            = cpl_valid_reg;
    assign cpl_dw0              = cpl_dw0_reg;
    assign attr_valid           = attr_active_reg;
    assign attr_index           = attr_idx_reg;
    assign attr_data            = attr_data_reg;

    // Fetch side
    assign fetch_req            = state_reg == HBF_WAIT && enable_reg;
    assign fetch_addr           = list_base + entry_offset;
    assign entry_valid          = ev_reg;
    assign entry_index          = fidx_reg;
    assign entry_page_count     = epc_reg;
    assign entry_host_address   = eha_reg;

    // Status
    assign buffer_enable_bit    = enable_reg;
    assign buffer_return_bit    = ret_reg;
    assign keepalive_timeout_ms = keepalive_timeout_ms_reg;
    assign keepalive_enabled    = keepalive_timeout_ms_reg != 32'h0000_0000;
    assign preboot_load_counter = pbc_reg;
    assign fetch_busy           = state_reg != HBF_IDLE;
endmodule

// >>> hbf_feature_ctrl_checker.sv
// Port assertions for the feature control block
`timescale 1ns/100ps
module hbf_checker (
    // Clock and reset
    input wire logic         clk,
    input wire logic         rst,
    // Command
    input wire logic         cmd_valid,
    input wire logic         cmd_is_set,
    input wire logic [7:0]   cmd_feature_id,
    input wire logic [31:0]  cmd_dw11,
    input wire logic [31:0]  cmd_dw15,
    // Completion and fetch
    input wire logic         cpl_valid,
    input wire logic [31:0]  cpl_dw0,
    input wire logic         fetch_req,
    input wire logic [63:0]  fetch_addr,
    input wire logic         fetch_ack,
    input wire logic [127:0] fetch_entry,
    input wire logic         entry_valid,
    input wire logic [31:0]  entry_index,
    input wire logic [31:0]  entry_page_count,
    input wire logic [63:0]  entry_host_address,
    // Status
    input wire logic         buffer_enable_bit,
    input wire logic         buffer_return_bit,
    input wire logic [31:0]  keepalive_timeout_ms,
    input wire logic         keepalive_enabled,
    input wire logic [7:0]   preboot_load_counter
);
    import hbf_pkg::*;
    logic        get_c;
    logic        set_c;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    assign get_c = cmd_valid && !cmd_is_set;
    assign set_c = cmd_valid && cmd_is_set;
    // Count stays with the last buffer set, since the host may not change it while enabled
    always_comb begin
        cnt_next = cnt_reg;
        if (set_c && cmd_feature_id == HBF_FID_HOSTBUF) cnt_next = cmd_dw15;
    end
    always_ff @(posedge clk) begin
        cnt_reg <= rst ? 32'h0 : cnt_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_cpl; cpl_valid == $past(cmd_valid); endproperty
    a_cpl: assert property (p_cpl) else $error("completion timing");
    property p_get_buf; get_c && cmd_feature_id == HBF_FID_HOSTBUF
        |=> cpl_dw0 == {30'h0, buffer_return_bit, buffer_enable_bit}; endproperty
    a_get_buf: assert property (p_get_buf) else $error("buffer read");
    property p_get_ka; get_c && cmd_feature_id == HBF_FID_KEEPALIVE
        |=> cpl_dw0 == keepalive_timeout_ms; endproperty
    a_get_ka: assert property (p_get_ka) else $error("timeout read");
    property p_get_cnt; get_c && cmd_feature_id == HBF_FID_PROGRESS
        |=> cpl_dw0 == {24'h0, preboot_load_counter}; endproperty
    a_get_cnt: assert property (p_get_cnt) else $error("counter read");
    property p_ka_en; keepalive_enabled == (keepalive_timeout_ms != 32'h0); endproperty
    a_ka_en: assert property (p_ka_en) else $error("timer enable");
    property p_set_cnt; set_c && cmd_feature_id == HBF_FID_PROGRESS
        |=> {24'h0, preboot_load_counter} == ($past(cmd_dw11) & 32'hff); endproperty
    a_set_cnt: assert property (p_set_cnt) else $error("counter write");
    property p_hold_cnt; !(set_c && cmd_feature_id == HBF_FID_PROGRESS)
        |=> $stable(preboot_load_counter); endproperty
    a_hold_cnt: assert property (p_hold_cnt) else $error("counter moved");
    property p_align; fetch_req |-> fetch_addr[3:0] == 4'h0; endproperty
    a_align: assert property (p_align) else $error("list address");
    property p_no_use; fetch_req |-> buffer_enable_bit; endproperty
    a_no_use: assert property (p_no_use) else $error("fetch while off");
    property p_entry; fetch_ack && fetch_req
        |=> entry_valid && {entry_page_count, entry_host_address} == 96'($past(fetch_entry));
    endproperty
    a_entry: assert property (p_entry) else $error("entry decode");
    property p_last; entry_valid |-> entry_index < cnt_reg; endproperty
    a_last: assert property (p_last) else $error("entry beyond count");
    c_get: cover property (get_c && cmd_feature_id == HBF_FID_HOSTBUF);
    c_entry: cover property (entry_valid);
    c_cnt: cover property (set_c && cmd_feature_id == HBF_FID_PROGRESS);
endmodule
bind hbf_feature_ctrl hbf_checker u_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_is_set(cmd_is_set), .cmd_feature_id(cmd_feature_id), .cmd_dw11(cmd_dw11),
    .cmd_dw15(cmd_dw15), .cpl_valid(cpl_valid), .cpl_dw0(cpl_dw0), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_entry(fetch_entry),
    .entry_valid(entry_valid), .entry_index(entry_index),
    .entry_page_count(entry_page_count), .entry_host_address(entry_host_address),
    .buffer_enable_bit(buffer_enable_bit), .buffer_return_bit(buffer_return_bit),
    .keepalive_timeout_ms(keepalive_timeout_ms), .keepalive_enabled(keepalive_enabled),
    .preboot_load_counter(preboot_load_counter));

// >>> hbf_host_mem.sv
// Host memory model answering descriptor fetches
`timescale 1ns/100ps
module hbf_host_mem (
    // Clock
    input  wire logic         clk,
    // Fetch port
    input  wire logic         fetch_req,
    input  wire logic [63:0]  fetch_addr,
    output logic              fetch_ack,
    output logic      [127:0] fetch_entry,
    // Answer delay in cycles
    input  wire logic [3:0]   lat
);
    logic [3:0] wait_cnt = 4'h0;
    initial fetch_ack = 1'b0;
    initial fetch_entry = '0;
    always @(posedge clk) begin
        fetch_ack <= 1'b0;
        // Stale data toggles so a late sample never looks valid
        fetch_entry <= ~fetch_entry;
        if (!fetch_req || fetch_ack) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt != lat) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            fetch_ack <= 1'b1;
            // Junk reserved bits, page-aligned address from one contiguous list
            fetch_entry <= {~fetch_addr[31:0], fetch_addr[35:4], fetch_addr[51:0], 12'h000};
        end
    end
endmodule

// >>> hbf_feature_ctrl_tb.sv
// Self-checking bench for the feature control block
`timescale 1ns/100ps
module hbf_feature_ctrl_tb;
    import hbf_pkg::*;
    logic         clk, rst, cmd_valid, cmd_is_set, fetch_ack, cpl_valid, attr_valid;
    logic         fetch_req, entry_valid, en_bit, ret_bit, ka_en, busy;
    logic [7:0]   cmd_id, counter;
    logic [9:0]   attr_index;
    logic [31:0]  dw11, dw12, dw13, dw14, dw15, p12, p13, p14, p15;
    logic [31:0]  cpl_dw0, attr_data, ka_ms, entry_index, entry_pages;
    logic [63:0]  fetch_addr, entry_addr;
    logic [127:0] fetch_entry;
    logic [3:0]   lat;
    int           miscompares, checked;
    hbf_feature_ctrl dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_is_set(cmd_is_set),
        .cmd_feature_id(cmd_id), .cmd_dw11(dw11), .cmd_dw12(dw12), .cmd_dw13(dw13),
        .cmd_dw14(dw14), .cmd_dw15(dw15), .cpl_valid(cpl_valid), .cpl_dw0(cpl_dw0),
        .attr_valid(attr_valid), .attr_index(attr_index), .attr_data(attr_data),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_entry(fetch_entry), .entry_valid(entry_valid), .entry_index(entry_index),
        .entry_page_count(entry_pages), .entry_host_address(entry_addr),
        .buffer_enable_bit(en_bit), .buffer_return_bit(ret_bit), .keepalive_timeout_ms(ka_ms),
        .keepalive_enabled(ka_en), .preboot_load_counter(counter), .fetch_busy(busy));
    hbf_host_mem u_mem (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack), .fetch_entry(fetch_entry), .lat(lat));
    always #4 clk = ~clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic set, input logic [7:0] id, input logic [31:0] d11);
        @(posedge clk);
        {cmd_valid, cmd_is_set, cmd_id, dw11} <= {1'b1, set, id, d11};
        {dw12, dw13, dw14, dw15} <= {p12, p13, p14, p15};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        check(cpl_valid, 1'b1);
    endtask
    task automatic t_reset;
        check({ka_ms, ka_en, counter, en_bit}, 42'h0);
        cmd(1'b0, 8'h42, 32'hffff_ffff);
        check(cpl_dw0, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_keepalive;
        logic [31:0] v[6] = '{32'h1, 32'h64, 32'h65, 32'hfa, 32'hffff_ffff, 32'h0};
        logic [63:0] e;
        foreach (v[i]) begin
            e = (64'(v[i]) + 64'(HBF_KEEPALIVE_GRAN) - 64'h1) / 64'(HBF_KEEPALIVE_GRAN);
            e = e * 64'(HBF_KEEPALIVE_GRAN);
            // Past the 32-bit range the setting falls back one step
            if (e[32]) begin
                e = e - 64'(HBF_KEEPALIVE_GRAN);
            end
            cmd(1'b1, HBF_FID_KEEPALIVE, v[i]);
            check({ka_ms, ka_en}, {e[31:0], e != 64'h0});
            cmd(1'b0, HBF_FID_KEEPALIVE, 32'h0);
            check(cpl_dw0, e[31:0]);
        end
        $display("keep-alive test done");
    endtask
    task automatic t_progress;
        cmd(1'b1, HBF_FID_PROGRESS, 32'habcd_12fe);
        check(counter, 8'hfe);
        cmd(1'b1, HBF_FID_PROGRESS, 32'h0000_00ff);
        cmd(1'b1, HBF_FID_KEEPALIVE, 32'h0);
        check(counter, 8'hff);
        cmd(1'b0, HBF_FID_PROGRESS, 32'h0);
        check(cpl_dw0, 32'h0000_00ff);
        cmd(1'b1, HBF_FID_PROGRESS, 32'h0);
        check(counter, 8'h00);
        $display("progress test done");
    endtask
    task automatic t_hostbuf(input logic [31:0] n, input logic [3:0] l);
        logic [63:0] a;
        logic [31:0] e;
        int k;
        lat = l;
        {p12, p13, p14, p15} = {32'h0000_0400, 32'h1234_567f, 32'h0000_0001, n};
        cmd(1'b1, HBF_FID_HOSTBUF, 32'h1);
        check(en_bit, 1'b1);
        k = 0;
        // Window long enough for every entry plus any stray fetch past the count
        repeat (200) begin
            @(posedge clk);
            #1;
            if (entry_valid === 1'b1) begin
                a = {p14, p13[31:4], 4'h0} + 64'(k) * 64'd16;
                check({entry_index, entry_pages}, {32'(k), a[35:4]});
                check(entry_addr, {a[51:0], 12'h000});
                k++;
            end
        end
        check(k, n);
        cmd(1'b0, HBF_FID_HOSTBUF, 32'h0);
        check(cpl_dw0, 32'h1);
        for (int i = 0; i < 1024; i++) begin
            e = (i == 0) ? p12 : (i == 1) ? {p13[31:4], 4'h0} : (i == 2) ? p14 : 32'h0;
            e = (i == 3) ? n : e;
            check({attr_valid, attr_index, attr_data}, {1'b1, 10'(i), e});
            @(posedge clk);
            #1;
        end
        check(attr_valid, 1'b0);
        cmd(1'b1, HBF_FID_HOSTBUF, 32'h2);
        cmd(1'b0, HBF_FID_HOSTBUF, 32'h0);
        check(cpl_dw0, 32'h2);
        check({en_bit, ret_bit}, 2'b01);
        repeat (20) begin
            @(posedge clk);
            #1;
            check(fetch_req, 1'b0);
        end
        check(busy, 1'b0);
        $display("host buffer test done");
    endtask
    task automatic t_cut;
        lat = 4'hf;
        {p12, p13, p14, p15} = {32'h0000_0010, 32'h0000_8000, 32'h0000_0000, 32'h4};
        cmd(1'b1, HBF_FID_HOSTBUF, 32'h1);
        check(busy, 1'b1);
        // Disable while the first read is still waiting for its answer
        cmd(1'b1, HBF_FID_HOSTBUF, 32'h0);
        check(fetch_req, 1'b0);
        repeat (20) begin
            @(posedge clk);
            #1;
            check({fetch_req, entry_valid}, 2'b00);
        end
        check(busy, 1'b0);
        $display("cut fetch test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {clk, cmd_valid, cmd_is_set, cmd_id, dw11, dw12, dw13, dw14, dw15} = '0;
        {p12, p13, p14, p15, lat, miscompares, checked} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_keepalive();
        t_progress();
        t_hostbuf(32'h3, 4'h1);
        t_cut();
        t_hostbuf(32'h1, 4'h6);
        t_hostbuf(32'h0, 4'h0);
        print_verdict();
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
